// [hw/chbp_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface chbp_bus_if;
	logic [chbp_pkg::ADDR_W-1:0] sys_addr;
	logic [chbp_pkg::DATA_W-1:0] sd_host_o;
	logic sd_host_oe;
	logic [chbp_pkg::DATA_W-1:0] sd_dev_o;
	logic sd_dev_oe;
	logic [chbp_pkg::DATA_W-1:0] sd_in;
	logic byte_high_n;
	logic io_rd_n;
	logic io_wr_n;
	logic mem_rd_n;
	logic mem_wr_n;
	logic rd_n;
	logic wr_n;
	logic video_mem_select_n;
	logic isolate;
	logic osc_inhibit;
	logic chan_ready_o;
	logic chan_ready_oe;
	logic io_cs16_n_o;
	logic io_cs16_oe;
	logic mem_cs16_n_o;
	logic mem_cs16_oe;
	logic video_data_valid;
	logic ring_out_n;
	logic speaker_out_n;
	logic irq;
	assign sd_in = sd_dev_oe ? sd_dev_o : (sd_host_oe ? sd_host_o : '0);
	modport dev (
		input sys_addr, sd_in, byte_high_n, io_rd_n, io_wr_n, mem_rd_n, mem_wr_n,
		input rd_n, wr_n, video_mem_select_n, isolate, osc_inhibit,
		output sd_dev_o, sd_dev_oe, chan_ready_o, chan_ready_oe, io_cs16_n_o, io_cs16_oe,
		output mem_cs16_n_o, mem_cs16_oe, video_data_valid, ring_out_n, speaker_out_n, irq
	);
	modport host (
		output sys_addr, sd_host_o, sd_host_oe, byte_high_n, io_rd_n, io_wr_n,
		output mem_rd_n, mem_wr_n, rd_n, wr_n, video_mem_select_n, isolate, osc_inhibit,
		input sd_in, chan_ready_o, chan_ready_oe, io_cs16_n_o, io_cs16_oe,
		input mem_cs16_n_o, mem_cs16_oe, video_data_valid, ring_out_n, speaker_out_n, irq
	);
endinterface
`default_nettype wire

// [hw/chbp_device.sv]
// Contract
// - 26-bit address, 16-bit two-way data
// - Byte-high enable is active low
// - Four active-low command strobes from host
// - Tri-state active-high channel ready output
// - Low io_cs16 marks 16-bit I/O
// - Low mem_cs16 marks 16-bit memory
// - Video select plus read/write strobe
// - Region bit: frame buffer or registers
// - Valid flag once read data driven
// - Isolation ignores all host accesses
// - Isolation, inhibit change only between accesses
// - Byte-high enable gated by isolation too
// - Oscillator inhibit stops crystal oscillation
// - Card ring forwarded to ring_out_n
// - Card speaker forwarded, active low
// - Runs from the host bus clock
// - All interrupt sources ORed to irq
`timescale 1ns/1ps
`default_nettype none
module chbp_device (
	input wire logic clk_sys,
	input wire logic rstn,
	chbp_bus_if.dev bus,
	input wire logic [chbp_pkg::ADDR_W-1:0] io_base,
	input wire logic card_ring_n,
	input wire logic card_speaker,
	input wire logic [3:0] irq_sources,
	output logic osc_enable,
	output logic [chbp_pkg::DATA_W-1:0] fb_wr_data,
	output logic fb_wr_strobe,
	output logic fb_wr_high_n,
	output logic [chbp_pkg::ADDR_W-1:0] fb_wr_addr,
	output logic vreg_wr_strobe,
	output logic io_wr_strobe,
	output logic [chbp_pkg::DATA_W-1:0] io_wr_data,
	input wire logic [chbp_pkg::DATA_W-1:0] fb_rd_data
);
	////////////////////////////////////////////////////////////////
	logic gate; // Isolation gates every host input except osc_inhibit
	logic io_hit, mem_hit, vid_hit, vid_rd, vid_wr, io_cyc, mem_cyc, any_cyc;
	logic vid_fb, vid_reg;
	logic [chbp_pkg::ADDR_W-1:0] a;
	logic bhe_n;
	chbp_pkg::chbp_state_type state_ff, nxt_state;
	logic [3:0] wait_ff;
	logic [chbp_pkg::DATA_W-1:0] rdata_ff;
	logic rd_oe_ff, valid_ff, ring_ff, spk_ff, irq_ff;
	logic [chbp_pkg::DATA_W-1:0] vreg_ff;
	logic done_edge, rd_cyc;

	function automatic logic addr_match(input logic [chbp_pkg::ADDR_W-1:0] x,
		input logic [chbp_pkg::ADDR_W-1:0] base, input logic [chbp_pkg::ADDR_W-1:0] mask);
		addr_match = ((x ^ base) & mask) == '0;
	endfunction

	assign gate = bus.isolate;
	assign a = gate ? '0 : bus.sys_addr;
	assign bhe_n = gate ? 1'b1 : bus.byte_high_n;
	assign io_hit = addr_match(a, io_base, chbp_pkg::IO_MASK);
	assign mem_hit = addr_match(a, chbp_pkg::MEM_BASE_DEF, chbp_pkg::MEM_MASK);
	assign io_cyc = !gate && io_hit && (!bus.io_rd_n || !bus.io_wr_n);
	assign mem_cyc = !gate && mem_hit && (!bus.mem_rd_n || !bus.mem_wr_n);
	assign vid_rd = !gate && !bus.video_mem_select_n && !bus.rd_n;
	assign vid_wr = !gate && !bus.video_mem_select_n && !bus.wr_n;
	assign vid_hit = vid_rd || vid_wr;
	assign vid_fb = vid_hit && !a[chbp_pkg::REGION_BIT];
	assign vid_reg = vid_hit && a[chbp_pkg::REGION_BIT];
	assign any_cyc = io_cyc || mem_cyc || vid_hit;
	assign done_edge = state_ff == chbp_pkg::ST_WAIT && nxt_state == chbp_pkg::ST_DONE;
	assign rd_cyc = vid_rd || (io_cyc && !bus.io_rd_n);

	////////////////////////////////////////////////////////////////
	// Wait states then ready, until strobes drop
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			chbp_pkg::ST_IDLE: if (any_cyc) nxt_state = chbp_pkg::ST_WAIT;
			chbp_pkg::ST_WAIT: begin
				if (!any_cyc) nxt_state = chbp_pkg::ST_IDLE;
				else if (wait_ff == 4'(chbp_pkg::WAIT_CYC - 1)) nxt_state = chbp_pkg::ST_DONE;
			end
			chbp_pkg::ST_DONE: if (!any_cyc) nxt_state = chbp_pkg::ST_IDLE;
			default: nxt_state = chbp_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) state_ff <= chbp_pkg::ST_IDLE;
		else state_ff <= nxt_state;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) wait_ff <= 4'h0;
		else if (state_ff == chbp_pkg::ST_WAIT) wait_ff <= wait_ff + 4'h1;
		else wait_ff <= 4'h0;
	end

	// Ready high only in ST_DONE, low before it; driven only when addressed
	assign bus.chan_ready_o = (state_ff == chbp_pkg::ST_DONE);
	assign bus.chan_ready_oe = any_cyc;
	assign bus.io_cs16_n_o = 1'b0;
	assign bus.io_cs16_oe = !gate && io_hit;
	assign bus.mem_cs16_n_o = 1'b0;
	assign bus.mem_cs16_oe = !gate && mem_hit;

	////////////////////////////////////////////////////////////////
	// Read data capture and drive
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= chbp_pkg::RESET_DATA;
		end else if (vid_reg) begin
			rdata_ff <= vreg_ff;
		end else if (vid_fb) begin
			rdata_ff <= fb_rd_data;
		end else if (io_cyc) begin
			rdata_ff <= chbp_pkg::VREG_ID;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_oe_ff <= 1'b0;
		end else begin
			rd_oe_ff <= rd_cyc && nxt_state == chbp_pkg::ST_DONE;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= vid_rd && nxt_state == chbp_pkg::ST_DONE;
		end
	end
	assign bus.sd_dev_o = rdata_ff;
	assign bus.sd_dev_oe = rd_oe_ff && any_cyc;
	assign bus.video_data_valid = valid_ff && vid_rd;

	////////////////////////////////////////////////////////////////
	// Write strobes, one per cycle at completion
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fb_wr_strobe <= 1'b0;
			fb_wr_data <= chbp_pkg::RESET_DATA;
			fb_wr_addr <= '0;
			fb_wr_high_n <= 1'b1;
		end else begin
			fb_wr_strobe <= 1'b0;
			if (done_edge && vid_wr && !a[chbp_pkg::REGION_BIT]) begin
				fb_wr_strobe <= 1'b1;
				fb_wr_data <= bus.sd_in;
				fb_wr_addr <= a;
				fb_wr_high_n <= bhe_n;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			vreg_wr_strobe <= 1'b0;
			vreg_ff <= chbp_pkg::RESET_DATA;
		end else begin
			vreg_wr_strobe <= 1'b0;
			if (done_edge && vid_wr && a[chbp_pkg::REGION_BIT]) begin
				vreg_wr_strobe <= 1'b1;
				vreg_ff <= bus.sd_in;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			io_wr_strobe <= 1'b0;
			io_wr_data <= chbp_pkg::RESET_DATA;
		end else begin
			io_wr_strobe <= 1'b0;
			if (done_edge && io_cyc && !bus.io_wr_n) begin
				io_wr_strobe <= 1'b1;
				io_wr_data <= bus.sd_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Pass-through outputs and interrupt
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ring_ff <= 1'b1;
		end else begin
			ring_ff <= card_ring_n;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			spk_ff <= 1'b1;
		end else begin
			spk_ff <= !card_speaker;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |irq_sources;
		end
	end
	assign bus.ring_out_n = ring_ff;
	assign bus.speaker_out_n = spk_ff;
	assign bus.irq = irq_ff;
	assign osc_enable = !bus.osc_inhibit;
endmodule
`default_nettype wire

// [hw/chbp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module chbp_host (
	input wire logic clk_sys,
	input wire logic rstn,
	chbp_bus_if.host bus,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_kind,
	input wire logic req_write,
	input wire logic req_high_n,
	input wire logic [chbp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [chbp_pkg::DATA_W-1:0] req_wdata,
	input wire logic req_isolate,
	input wire logic req_osc_inhibit,
	output logic rsp_valid,
	output logic [chbp_pkg::DATA_W-1:0] rsp_rdata,
	output logic rsp_wide,
	output logic irq_seen
);
	// Request kinds: 0 io, 1 mem, 2 video
	chbp_pkg::chbp_state_type state_ff;
	logic [1:0] kind_ff;
	logic wr_ff, act_ff, iso_ff, inh_ff;
	logic [chbp_pkg::ADDR_W-1:0] addr_ff;
	logic [chbp_pkg::DATA_W-1:0] wdata_ff;
	logic hi_n_ff;

	assign req_ready = state_ff == chbp_pkg::ST_IDLE;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= chbp_pkg::ST_IDLE;
			act_ff <= 1'b0;
			kind_ff <= 2'h0;
			wr_ff <= 1'b0;
			addr_ff <= '0;
			wdata_ff <= '0;
			hi_n_ff <= 1'b1;
			iso_ff <= 1'b0;
			inh_ff <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			rsp_wide <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			case (state_ff)
				chbp_pkg::ST_IDLE: begin
					iso_ff <= req_isolate;
					inh_ff <= req_osc_inhibit;
					if (req_valid) begin
						act_ff <= 1'b1;
						kind_ff <= req_kind;
						wr_ff <= req_write;
						addr_ff <= req_addr;
						wdata_ff <= req_wdata;
						hi_n_ff <= req_high_n;
						state_ff <= chbp_pkg::ST_WAIT;
					end
				end
				chbp_pkg::ST_WAIT: begin
					if (bus.chan_ready_oe && bus.chan_ready_o) begin
						rsp_rdata <= bus.sd_in;
						rsp_wide <= kind_ff == 2'h0 ? (bus.io_cs16_oe && !bus.io_cs16_n_o)
							: (bus.mem_cs16_oe && !bus.mem_cs16_n_o);
						act_ff <= 1'b0;
						state_ff <= chbp_pkg::ST_DONE;
					end else if (iso_ff) begin
						rsp_wide <= 1'b0;
						act_ff <= 1'b0;
						state_ff <= chbp_pkg::ST_DONE;
					end
				end
				chbp_pkg::ST_DONE: begin
					rsp_valid <= 1'b1;
					state_ff <= chbp_pkg::ST_IDLE;
				end
				default: state_ff <= chbp_pkg::ST_IDLE;
			endcase
		end
	end

	assign bus.sys_addr = addr_ff;
	assign bus.byte_high_n = hi_n_ff;
	assign bus.sd_host_o = wdata_ff;
	assign bus.sd_host_oe = act_ff && wr_ff;
	assign bus.io_rd_n = !(act_ff && kind_ff == 2'h0 && !wr_ff);
	assign bus.io_wr_n = !(act_ff && kind_ff == 2'h0 && wr_ff);
	assign bus.mem_rd_n = !(act_ff && kind_ff == 2'h1 && !wr_ff);
	assign bus.mem_wr_n = !(act_ff && kind_ff == 2'h1 && wr_ff);
	assign bus.video_mem_select_n = !(act_ff && kind_ff == 2'h2);
	assign bus.rd_n = !(act_ff && kind_ff == 2'h2 && !wr_ff);
	assign bus.wr_n = !(act_ff && kind_ff == 2'h2 && wr_ff);
	assign bus.isolate = iso_ff;
	assign bus.osc_inhibit = inh_ff;
	assign irq_seen = bus.irq;
endmodule
`default_nettype wire

// [hw/chbp_pkg.sv]
package chbp_pkg;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int REGION_BIT = 23;
	localparam int IO_BASE_W = 10;
	localparam logic [ADDR_W-1:0] IO_BASE_DEF = 26'h00003e0;
	localparam logic [ADDR_W-1:0] IO_MASK = 26'h3fffffe;
	localparam logic [ADDR_W-1:0] MEM_BASE_DEF = 26'h1000000;
	localparam logic [ADDR_W-1:0] MEM_MASK = 26'h3ff0000;
	localparam int CLK_HZ = 10000000;
	localparam int BUS_CLK_NOM_HZ = 8000000;
	localparam int WAIT_NS = 200;
	localparam int WAIT_CYC = (WAIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [DATA_W-1:0] RESET_DATA = 16'h0000;
	localparam logic [DATA_W-1:0] VREG_ID = 16'h5a01; // Arbitrary value
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b11
	} chbp_state_type;
endpackage

// [verification/chbp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module chbp_properties (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic io_rd_n,
	input wire logic io_wr_n,
	input wire logic mem_rd_n,
	input wire logic mem_wr_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic video_mem_select_n,
	input wire logic isolate,
	input wire logic chan_ready_o,
	input wire logic chan_ready_oe,
	input wire logic io_cs16_n_o,
	input wire logic io_cs16_oe,
	input wire logic mem_cs16_n_o,
	input wire logic mem_cs16_oe,
	input wire logic sd_dev_oe,
	input wire logic video_data_valid
);
	logic cmd;
	logic rdy;
	assign cmd = !(io_rd_n && io_wr_n && mem_rd_n && mem_wr_n)
		|| (!video_mem_select_n && !(rd_n && wr_n));
	assign rdy = chan_ready_oe && chan_ready_o;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	property p_rdy_cause; chan_ready_oe |-> cmd && !isolate; endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("ready outside cycle");
	property p_rdy_late; $rose(cmd) && !isolate |-> !rdy [*2]; endproperty
	a_rdy_late: assert property (p_rdy_late) else $error("ready early");
	property p_rdy_bound; $rose(cmd) && !isolate |-> ##[1:6] rdy; endproperty
	a_rdy_bound: assert property (p_rdy_bound) else $error("ready missing");
	property p_io16; io_cs16_oe |-> !io_cs16_n_o; endproperty
	a_io16: assert property (p_io16) else $error("io width high");
	property p_mem16; mem_cs16_oe |-> !mem_cs16_n_o; endproperty
	a_mem16: assert property (p_mem16) else $error("mem width high");
	property p_valid; video_data_valid |-> sd_dev_oe && !video_mem_select_n && !rd_n; endproperty
	a_valid: assert property (p_valid) else $error("valid without read");
	property p_rd_due;
		rdy && !video_mem_select_n && !rd_n |-> video_data_valid && sd_dev_oe;
	endproperty
	a_rd_due: assert property (p_rd_due) else $error("read data not flagged");
	property p_iso;
		isolate && $past(isolate) |-> !chan_ready_oe && !sd_dev_oe && !video_data_valid;
	endproperty
	a_iso: assert property (p_iso) else $error("drive while isolated");
	property p_iso16; isolate && $past(isolate) |-> !io_cs16_oe && !mem_cs16_oe; endproperty
	a_iso16: assert property (p_iso16) else $error("width while isolated");
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_sys = 0, rstn = 0, req_valid = 0, req_write = 0, req_high_n = 1;
	logic req_isolate = 0, req_osc_inhibit = 0, card_ring_n = 1, card_speaker = 0;
	logic req_ready, rsp_valid, rsp_wide, irq_seen, osc_enable, fb_wr_strobe, fb_wr_high_n;
	logic vreg_wr_strobe, io_wr_strobe, last_hn;
	logic [25:0] last_fa;
	logic [1:0] req_kind = 0;
	logic [3:0] irq_sources = 0;
	logic [25:0] req_addr = 0, io_base = chbp_pkg::IO_BASE_DEF, fb_wr_addr;
	logic [15:0] req_wdata = 0, fb_rd_data = 16'hc3a5, rsp_rdata, fb_wr_data, io_wr_data, last_wd;
	int n_errors = 0, n_compared = 0, n_fb = 0, n_vr = 0, n_io = 0;
	chbp_bus_if bus ();
	chbp_device chbp_device_inst (.clk_sys, .rstn, .bus, .io_base, .card_ring_n, .card_speaker,
		.irq_sources, .osc_enable, .fb_wr_data, .fb_wr_strobe, .fb_wr_high_n, .fb_wr_addr,
		.vreg_wr_strobe, .io_wr_strobe, .io_wr_data, .fb_rd_data);
	chbp_host chbp_host_inst (.clk_sys, .rstn, .bus, .req_valid, .req_ready, .req_kind, .req_write,
		.req_high_n, .req_addr, .req_wdata, .req_isolate, .req_osc_inhibit, .rsp_valid, .rsp_rdata,
		.rsp_wide, .irq_seen);
	chbp_properties chbp_properties_inst (.clk_sys, .rstn, .io_rd_n(bus.io_rd_n),
		.io_wr_n(bus.io_wr_n), .mem_rd_n(bus.mem_rd_n), .mem_wr_n(bus.mem_wr_n), .rd_n(bus.rd_n),
		.wr_n(bus.wr_n), .video_mem_select_n(bus.video_mem_select_n), .isolate(bus.isolate),
		.chan_ready_o(bus.chan_ready_o), .chan_ready_oe(bus.chan_ready_oe),
		.io_cs16_n_o(bus.io_cs16_n_o), .io_cs16_oe(bus.io_cs16_oe),
		.mem_cs16_n_o(bus.mem_cs16_n_o), .mem_cs16_oe(bus.mem_cs16_oe),
		.sd_dev_oe(bus.sd_dev_oe), .video_data_valid(bus.video_data_valid));
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		n_fb <= n_fb + fb_wr_strobe;
		n_vr <= n_vr + vreg_wr_strobe;
		n_io <= n_io + io_wr_strobe;
		if (fb_wr_strobe) begin
			last_hn <= fb_wr_high_n;
			last_fa <= fb_wr_addr;
		end
		if (fb_wr_strobe || io_wr_strobe) last_wd <= fb_wr_strobe ? fb_wr_data : io_wr_data;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// One access, returns at the negedge where the response shows
	task automatic xfer(input logic [1:0] k, input logic w, input logic [25:0] a,
		input logic [15:0] d);
		int i;
		req_kind = k;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_valid = 1;
		i = 0;
		while (req_ready !== 1'b1 && i < 40) begin
			@(negedge clk_sys);
			i++;
		end
		@(negedge clk_sys);
		req_valid = 0;
		while (rsp_valid !== 1'b1 && i < 40) begin
			@(negedge clk_sys);
			i++;
		end
		if (i >= 40) begin
			n_errors++;
			$display("unexpected at %0t: no response", $time);
			end_sim;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_io;
		xfer(2'h0, 1'h1, chbp_pkg::IO_BASE_DEF, 16'h1e2d);
		chk(16'(n_io), 16'h0001);
		chk(last_wd, 16'h1e2d);
		xfer(2'h0, 1'h0, chbp_pkg::IO_BASE_DEF + 26'h1, 16'h0000);
		chk(rsp_rdata, chbp_pkg::VREG_ID);
		chk(16'(rsp_wide), 16'h0001);
		xfer(2'h1, 1'h0, chbp_pkg::MEM_BASE_DEF + 26'hfffe, 16'h0000);
		chk(16'(rsp_wide), 16'h0001);
	endtask
	task automatic t_video;
		req_high_n = 1'h0;
		xfer(2'h2, 1'h1, 26'h0000010, 16'h8421);
		chk(16'(n_fb), 16'h0001);
		chk(last_wd, 16'h8421);
		chk(16'(last_hn), 16'h0000);
		chk(16'(last_fa), 16'h0010);
		xfer(2'h2, 1'h1, 26'h0800004, 16'h1234);
		chk(16'(n_vr * 2 + n_fb), 16'h0003);
		xfer(2'h2, 1'h0, 26'h0000010, 16'h0000);
		chk(rsp_rdata, 16'hc3a5);
		xfer(2'h2, 1'h0, 26'h0800004, 16'h0000);
		chk(rsp_rdata, 16'h1234);
	endtask
	task automatic t_iso;
		xfer(2'h1, 1'h0, chbp_pkg::MEM_BASE_DEF, 16'h0000);
		chk(16'(rsp_wide), 16'h0001);
		req_isolate = 1'h1;
		repeat (2) @(negedge clk_sys);
		xfer(2'h0, 1'h1, chbp_pkg::IO_BASE_DEF, 16'h7777);
		chk(16'(rsp_wide), 16'h0000);
		chk(16'(bus.io_cs16_oe), 16'h0000);
		xfer(2'h2, 1'h1, 26'h0000010, 16'h7777);
		chk(16'(n_io + n_fb), 16'h0002);
		req_isolate = 1'h0;
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic t_side;
		for (int p = 0; p < 2; p++) begin
			card_ring_n = p[0];
			card_speaker = !p[0];
			irq_sources = p[0] ? 4'h0 : 4'h8;
			req_osc_inhibit = !p[0];
			repeat (3) @(negedge clk_sys);
			chk(16'(bus.ring_out_n), 16'(p[0]));
			chk(16'(bus.speaker_out_n), 16'(p[0]));
			chk(16'(irq_seen), 16'(!p[0]));
			chk(16'(osc_enable), 16'(p[0]));
		end
	endtask
	initial begin
		repeat (2) @(negedge clk_sys);
		rstn = 1;
		t_io;
		t_video;
		t_iso;
		t_side;
		end_sim;
	end
endmodule
`default_nettype wire
